// [core/pmcs_cfg.svh]
// Command codes, settings defaults and limits of the command set handler
`ifndef PMCS_CFG_SVH
`define PMCS_CFG_SVH
`define PMCS_CMD_OP     8'h01
`define PMCS_CMD_ONOFF  8'h02
`define PMCS_CMD_CLR    8'h03
`define PMCS_CMD_WP     8'h10
`define PMCS_CMD_SAVE   8'h11
`define PMCS_CMD_LOAD   8'h12
`define PMCS_CMD_MODE   8'h20
`define PMCS_CMD_VSET   8'h21
`define PMCS_CMD_OVF    8'h40
`define PMCS_CMD_OVW    8'h42
`define PMCS_CMD_OCF    8'h46
`define PMCS_CMD_OCW    8'h4a
`define PMCS_CMD_OTF    8'h4f
`define PMCS_CMD_FREQ   8'h95
`define PMCS_CMD_REV    8'h98
`define PMCS_CMD_KEY    8'hec
`define PMCS_NREG       9
`define PMCS_IX_OP      4'h0
`define PMCS_IX_ONOFF   4'h1
`define PMCS_IX_WP      4'h2
`define PMCS_IX_VSET    4'h3
`define PMCS_IX_OVF     4'h4
`define PMCS_IX_OVW     4'h5
`define PMCS_IX_OCF     4'h6
`define PMCS_IX_OCW     4'h7
`define PMCS_IX_OTF     4'h8
`define PMCS_IX_NONE    4'hf
`define PMCS_OP_RST     16'h0080
`define PMCS_OP_MASK    16'h0080
`define PMCS_ONOFF_RST  16'h001d
`define PMCS_ONOFF_MASK 16'h001f
`define PMCS_WP_RST     16'h0080
`define PMCS_WP_ALL     8'h80
`define PMCS_WP_OPER    8'h40
`define PMCS_WP_CFG     8'h20
`define PMCS_WP_NONE    8'h00
`define PMCS_BYTE_MASK  16'h00ff
`define PMCS_VSET_RST   16'hc333
`define PMCS_OVF_RST    16'hd800
`define PMCS_OVF_MIN    16'hd000
`define PMCS_OVF_MAX    16'he000
`define PMCS_OVW_RST    16'hd000
`define PMCS_OVW_MIN    16'hc000
`define PMCS_OVW_MAX    16'hd000
`define PMCS_OCF_RST    16'heb50
`define PMCS_OCF_MIN    16'heaa8
`define PMCS_OCF_MAX    16'heb50
`define PMCS_OCW_RST    16'heb20
`define PMCS_OCW_MIN    16'heaa8
`define PMCS_OCW_MAX    16'heb20
`define PMCS_OTF_RST    16'hf208
`define PMCS_OTF_MIN    16'hf1f4
`define PMCS_OTF_MAX    16'hf21c
`define PMCS_MODE_VAL   16'h0014
`define PMCS_REV_VAL    16'h0022
`define PMCS_FREQ_EXP   5'h01
`define PMCS_RD_NONE    16'hffff
`define PMCS_KEY_WORD   16'h157e
`define PMCS_ONOFF_PU   4
`define PMCS_ONOFF_CMD  3
`define PMCS_ONOFF_CPR  2
`define PMCS_ONOFF_POL  1
`define PMCS_OP_ON      7
`define PMCS_BIT_ACK    4'h8
`define PMCS_BIT_LAST   4'h7
`define PMCS_IDX_ADDR   3'h0
`define PMCS_IDX_CMD    3'h1
`define PMCS_IDX_DLO    3'h2
`define PMCS_IDX_DHI    3'h3
`define PMCS_IDX_MAX    3'h7
`endif

// [core/pmcs_pkg.sv]
// Types shared by the command set handler modules
package pmcs_pkg;
	typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_SAVE = 3'h2, ST_LOAD = 3'h4} pmcs_state_t;
	typedef enum logic {KIND_LOOK = 1'h0, KIND_COMMIT = 1'h1} pmcs_kind_t;
endpackage

// [core/pmcs_xfer_if.sv]
// Toggle handshake channel between link engine and command core
`timescale 1ns/1ps
interface pmcs_xfer_if;
	import pmcs_pkg::*;
	logic       req_tog;
	pmcs_kind_t kind;
	logic [7:0] cmd;
	logic [15:0] data;
	logic [2:0] nbytes;
	logic       ack_tog;
	logic [15:0] rdata;
	modport link (output req_tog, kind, cmd, data, nbytes, input ack_tog, rdata);
	modport core (input req_tog, kind, cmd, data, nbytes, output ack_tog, rdata);
endinterface

// [core/pmcs_flash.sv]
// Non-volatile settings store
`timescale 1ns/1ps
module pmcs_flash #(
	parameter int NREG = 9,
	parameter int W    = 16
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic         i_we,
	input  wire logic [3:0]   i_addr,
	input  wire logic [W-1:0] i_wdata,
	output logic      [W-1:0] o_rdata,
	output logic              o_holds
);
	logic [W-1:0] mem [NREG];

	if (NREG < 1 || NREG > 15 || W < 1) begin : g_bad
		$error("pmcs_flash: NREG or W out of range");
	end

	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end

	// Blank until first save
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_holds <= 1'h0;
		end else if (i_we) begin
			o_holds <= 1'h1;
		end
	end

	assign o_rdata = mem[i_addr];
endmodule

// [core/pmcs_link.sv]
// Management bus byte engine on the link clock
`timescale 1ns/1ps
`include "pmcs_cfg.svh"
module pmcs_link
	import pmcs_pkg::*;
	#(
	parameter logic [6:0] ADDR = 7'h60
) (
	input  wire logic  i_link_clock,
	input  wire logic  i_link_rst,
	input  wire logic  i_scl,
	input  wire logic  i_sda,
	output logic       o_sda,
	output logic       o_sda_oe,
	pmcs_xfer_if.link  xfer
);
	logic [2:0]  scl_p;
	logic [2:0]  sda_p;
	logic        scl_q;
	logic        sda_q;
	logic        scl_d;
	logic        sda_d;
	logic [1:0]  ack_p;
	logic        ack_seen;
	logic [15:0] rword;
	logic [3:0]  bit_cnt;
	logic [2:0]  idx;
	logic [7:0]  shreg;
	logic [7:0]  out;
	logic        me;
	logic        rd;
	logic        nack;
	logic        start;
	logic        stop;
	logic        rise;
	logic        fall;
	logic        fresh;  // Start seen, no data clock yet

	assign start = scl_q && scl_d && sda_d && !sda_q;
	assign stop  = scl_q && scl_d && !sda_d && sda_q;
	assign rise  = scl_q && !scl_d;
	assign fall  = !scl_q && scl_d;

	// Pin filters: change accepted once stages two and three agree
	always_ff @(posedge i_link_clock) begin
		if (i_link_rst) begin
			scl_p <= 3'h7;
			sda_p <= 3'h7;
			scl_q <= 1'h1;
			sda_q <= 1'h1;
			scl_d <= 1'h1;
			sda_d <= 1'h1;
		end else begin
			scl_p <= {scl_p[1:0], i_scl};
			sda_p <= {sda_p[1:0], i_sda};
			if (scl_p[1] == scl_p[2]) begin
				scl_q <= scl_p[2];
			end
			if (sda_p[1] == sda_p[2]) begin
				sda_q <= sda_p[2];
			end
			scl_d <= scl_q;
			sda_d <= sda_q;
		end
	end

	// Read word returned by the core
	always_ff @(posedge i_link_clock) begin
		if (i_link_rst) begin
			ack_p    <= 2'h0;
			ack_seen <= 1'h0;
			rword    <= `PMCS_RD_NONE;
		end else begin
			ack_p <= {ack_p[0], xfer.ack_tog};
			if (ack_p[1] != ack_seen) begin
				ack_seen <= ack_p[1];
				rword    <= xfer.rdata;
			end
		end
	end

	// Frame engine
	always_ff @(posedge i_link_clock) begin
		if (i_link_rst) begin
			bit_cnt      <= 4'h0;
			idx          <= `PMCS_IDX_ADDR;
			shreg        <= 8'h00;
			out          <= 8'hff;
			me           <= 1'h0;
			rd           <= 1'h0;
			nack         <= 1'h0;
			o_sda        <= 1'h0;
			o_sda_oe     <= 1'h0;
			xfer.req_tog <= 1'h0;
			xfer.kind    <= KIND_LOOK;
			xfer.cmd     <= 8'h00;
			xfer.data    <= 16'h0000;
			xfer.nbytes  <= 3'h0;
			fresh        <= 1'h1;
		end else if (start || stop) begin
			if (stop && me && !rd && idx >= `PMCS_IDX_DLO) begin
				xfer.kind    <= KIND_COMMIT;
				xfer.nbytes  <= idx - `PMCS_IDX_DLO;
				xfer.req_tog <= ~xfer.req_tog;
			end
			bit_cnt  <= 4'h0;
			idx      <= `PMCS_IDX_ADDR;
			me       <= 1'h0;
			nack     <= 1'h0;
			o_sda_oe <= 1'h0;
			fresh    <= 1'h1;
		end else if (rise) begin
			fresh <= 1'h0;
			if (bit_cnt != `PMCS_BIT_ACK) begin
				shreg <= {shreg[6:0], sda_q};
			end else if (me && rd && sda_q) begin
				nack <= 1'h1;
			end
		end else if (fall && !fresh) begin
			if (bit_cnt == `PMCS_BIT_LAST) begin
				bit_cnt  <= `PMCS_BIT_ACK;
				o_sda_oe <= 1'h0;
				if (idx == `PMCS_IDX_ADDR) begin
					me       <= shreg[7:1] == ADDR;
					rd       <= shreg[0];
					o_sda_oe <= shreg[7:1] == ADDR;
				end else if (me && !rd) begin
					o_sda_oe <= 1'h1;
					if (idx == `PMCS_IDX_CMD) begin
						xfer.cmd     <= shreg;
						xfer.kind    <= KIND_LOOK;
						xfer.req_tog <= ~xfer.req_tog;
					end else if (idx == `PMCS_IDX_DLO) begin
						xfer.data[7:0] <= shreg;
					end else if (idx == `PMCS_IDX_DHI) begin
						xfer.data[15:8] <= shreg;
					end
				end
			end else if (bit_cnt == `PMCS_BIT_ACK) begin
				bit_cnt <= 4'h0;
				if (idx != `PMCS_IDX_MAX) begin
					idx <= idx + 3'h1;
				end
				if (me && rd && !nack) begin
					out <= (idx == `PMCS_IDX_ADDR) ? rword[7:0] :
						(idx == `PMCS_IDX_CMD) ? rword[15:8] : 8'hff;
					o_sda_oe <= (idx == `PMCS_IDX_ADDR) ? !rword[7] :
						(idx == `PMCS_IDX_CMD) ? !rword[15] : 1'h0;
				end else begin
					o_sda_oe <= 1'h0;
				end
			end else begin
				bit_cnt <= bit_cnt + 4'h1;
				if (me && rd && !nack) begin
					out      <= {out[6:0], 1'h1};
					o_sda_oe <= !out[6];
				end
			end
		end
	end
endmodule

// [core/pmcs_handler.sv]
// Command core of the power module management interface
`timescale 1ns/1ps
`include "pmcs_cfg.svh"
// Behaviour
// - Byte command 0x01 switches the output on or off; resets to 0x80.
// - Byte command 0x10 guards bus writes; resets to 0x80.
// - Send-byte 0x11 copies the working settings into data flash.
// - Save needs a prior unlock key at 0xEC; all settings but the key saved.
// - Code 0x21 is a read-only word setpoint, exponent -12, default 12.2 V.
// - Code 0x95 reads switching frequency in kHz, linear, exponent 1.
// - Code 0x40 overvoltage fault limit word, default 13.5 V, range 13-14 V.
// - Code 0x42 overvoltage warning limit word, default 13 V, range 12-13 V.
// - Code 0x46 overcurrent fault limit, exponent -3, default 106 A, 85-106 A.
// - Code 0x4A overcurrent warning, default 100 A, 85-100 A, below fault limit.
// - Code 0x4F overtemperature fault, exponent -2, default 130 C, 125-135 C.
// - Main command set of bus revision 1.2, deviations per command.
// - Output voltage values use unsigned mantissa with fixed exponent -12.
// - Fault clear send-byte clears latched faults and releases the alert line.
module pmcs_handler
	import pmcs_pkg::*;
	#(
	parameter logic [6:0] ADDR = 7'h60,
	parameter int         FW   = 8
) (
	input  wire logic          i_clock,
	input  wire logic          i_rst,
	input  wire logic          i_link_clock,
	input  wire logic          i_link_rst,
	input  wire logic          i_scl,
	input  wire logic          i_sda,
	output logic               o_sda,
	output logic               o_sda_oe,
	input  wire logic          i_on_off_pin,
	input  wire logic [FW-1:0] i_fault_evt,
	input  wire logic [11:0]   i_freq_khz,
	output logic               o_output_on,
	output logic               o_alert_n,
	output logic               o_alert_oe,
	output logic [FW-1:0]      o_faults,
	output logic [15:0]        o_vout_setpoint,
	output logic [15:0]        o_ov_fault_limit,
	output logic [15:0]        o_ov_warn_limit,
	output logic [15:0]        o_oc_fault_limit,
	output logic [15:0]        o_oc_warn_limit,
	output logic [15:0]        o_overtemperature_fault_limit
);
	localparam int NREG = `PMCS_NREG;

	if (FW < 1) begin : g_bad
		$error("pmcs_handler: FW must be at least one");
	end

	pmcs_xfer_if xfer();

	pmcs_state_t st;
	logic [15:0] param [NREG];
	logic [3:0]  step;
	logic [1:0]  req_s;
	logic        req_seen;
	logic [15:0] next_rdata;
	logic [3:0]  look_ix;
	logic        unlocked;
	logic [2:0]  pin_p;
	logic        pin_q;
	logic [15:0] fl_rdata;
	logic        fl_holds;
	logic        fl_we;
	logic        take;
	logic        commit;
	logic        wr_ok;
	logic [3:0]  wr_ix;
	logic [15:0] wval;
	logic        width_ok;
	logic        apply_write;
	logic        clear_go;
	logic        save_go;
	logic        load_go;
	logic        key_go;
	logic        pin_on;

	function automatic logic [3:0] cmd_index(input logic [7:0] c);
		case (c)
			`PMCS_CMD_OP: cmd_index = `PMCS_IX_OP;
			`PMCS_CMD_ONOFF: cmd_index = `PMCS_IX_ONOFF;
			`PMCS_CMD_WP: cmd_index = `PMCS_IX_WP;
			`PMCS_CMD_VSET: cmd_index = `PMCS_IX_VSET;
			`PMCS_CMD_OVF: cmd_index = `PMCS_IX_OVF;
			`PMCS_CMD_OVW: cmd_index = `PMCS_IX_OVW;
			`PMCS_CMD_OCF: cmd_index = `PMCS_IX_OCF;
			`PMCS_CMD_OCW: cmd_index = `PMCS_IX_OCW;
			`PMCS_CMD_OTF: cmd_index = `PMCS_IX_OTF;
			default: cmd_index = `PMCS_IX_NONE;
		endcase
	endfunction

	function automatic logic [15:0] default_of(input logic [3:0] ix);
		case (ix)
			`PMCS_IX_OP: default_of = `PMCS_OP_RST;
			`PMCS_IX_ONOFF: default_of = `PMCS_ONOFF_RST;
			`PMCS_IX_WP: default_of = `PMCS_WP_RST;
			`PMCS_IX_VSET: default_of = `PMCS_VSET_RST;
			`PMCS_IX_OVF: default_of = `PMCS_OVF_RST;
			`PMCS_IX_OVW: default_of = `PMCS_OVW_RST;
			`PMCS_IX_OCF: default_of = `PMCS_OCF_RST;
			`PMCS_IX_OCW: default_of = `PMCS_OCW_RST;
			default: default_of = `PMCS_OTF_RST;
		endcase
	endfunction

	function automatic logic in_win(input logic [15:0] d, input logic [15:0] lo, input logic [15:0] hi);
		in_win = d >= lo && d <= hi;
	endfunction

	// Range and ordering checks per setting
	function automatic logic legal(input logic [3:0] ix, input logic [15:0] d,
		input logic [15:0] ocf, input logic [15:0] ocw);
		case (ix)
			`PMCS_IX_OP, `PMCS_IX_ONOFF: legal = 1'h1;
			`PMCS_IX_WP: legal = d[7:0] == `PMCS_WP_ALL || d[7:0] == `PMCS_WP_OPER ||
				d[7:0] == `PMCS_WP_CFG || d[7:0] == `PMCS_WP_NONE;
			`PMCS_IX_OVF: legal = in_win(d, `PMCS_OVF_MIN, `PMCS_OVF_MAX);
			`PMCS_IX_OVW: legal = in_win(d, `PMCS_OVW_MIN, `PMCS_OVW_MAX);
			`PMCS_IX_OCF: legal = in_win(d, `PMCS_OCF_MIN, `PMCS_OCF_MAX) && d > ocw;
			`PMCS_IX_OCW: legal = in_win(d, `PMCS_OCW_MIN, `PMCS_OCW_MAX) && d < ocf;
			`PMCS_IX_OTF: legal = in_win(d, `PMCS_OTF_MIN, `PMCS_OTF_MAX);
			default: legal = 1'h0;
		endcase
	endfunction

	function automatic logic [15:0] shape(input logic [3:0] ix, input logic [15:0] d);
		case (ix)
			`PMCS_IX_OP: shape = d & `PMCS_OP_MASK;
			`PMCS_IX_ONOFF: shape = d & `PMCS_ONOFF_MASK;
			`PMCS_IX_WP: shape = d & `PMCS_BYTE_MASK;
			default: shape = d;
		endcase
	endfunction

	// Write guard levels
	function automatic logic guard_allows(input logic [7:0] g, input logic [7:0] c);
		case (g)
			`PMCS_WP_ALL: guard_allows = c == `PMCS_CMD_WP;
			`PMCS_WP_OPER: guard_allows = c == `PMCS_CMD_WP || c == `PMCS_CMD_OP;
			`PMCS_WP_CFG: guard_allows = c == `PMCS_CMD_WP || c == `PMCS_CMD_OP ||
				c == `PMCS_CMD_ONOFF || c == `PMCS_CMD_VSET;
			default: guard_allows = 1'h1;
		endcase
	endfunction

	pmcs_link #(
		.ADDR (ADDR)
	) u_link (
		.i_link_clock (i_link_clock),
		.i_link_rst   (i_link_rst),
		.i_scl        (i_scl),
		.i_sda        (i_sda),
		.o_sda        (o_sda),
		.o_sda_oe     (o_sda_oe),
		.xfer         (xfer.link)
	);

	pmcs_flash #(
		.NREG (NREG),
		.W    (16)
	) u_flash (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_we    (fl_we),
		.i_addr  (step),
		.i_wdata (param[step]),
		.o_rdata (fl_rdata),
		.o_holds (fl_holds)
	);

	// Command decode
	assign take        = req_s[1] != req_seen && st == ST_IDLE;
	assign commit      = take && xfer.kind == KIND_COMMIT;
	assign wr_ok       = commit && guard_allows(param[`PMCS_IX_WP][7:0], xfer.cmd);
	assign wr_ix       = cmd_index(xfer.cmd);
	assign wval        = shape(wr_ix, xfer.data);
	assign width_ok    = (wr_ix <= `PMCS_IX_WP) ? xfer.nbytes == 3'h1 : xfer.nbytes == 3'h2;
	assign apply_write = wr_ok && wr_ix != `PMCS_IX_NONE && width_ok &&
		legal(wr_ix, wval, param[`PMCS_IX_OCF], param[`PMCS_IX_OCW]);
	assign clear_go    = wr_ok && xfer.cmd == `PMCS_CMD_CLR && xfer.nbytes == 3'h0;
	assign save_go     = wr_ok && xfer.cmd == `PMCS_CMD_SAVE && xfer.nbytes == 3'h0 && unlocked;
	assign load_go     = wr_ok && xfer.cmd == `PMCS_CMD_LOAD && xfer.nbytes == 3'h0 && !o_output_on;
	assign key_go      = wr_ok && xfer.cmd == `PMCS_CMD_KEY && xfer.nbytes >= 3'h2 &&
		xfer.data == `PMCS_KEY_WORD;
	assign fl_we       = st == ST_SAVE;

	// Read answers
	always_comb begin
		look_ix    = cmd_index(xfer.cmd);
		next_rdata = `PMCS_RD_NONE;
		if (look_ix != `PMCS_IX_NONE) begin
			next_rdata = param[look_ix];
		end else begin
			case (xfer.cmd)
				`PMCS_CMD_MODE: next_rdata = `PMCS_MODE_VAL;
				`PMCS_CMD_FREQ: next_rdata = {`PMCS_FREQ_EXP, i_freq_khz[11:1]};
				`PMCS_CMD_REV: next_rdata = `PMCS_REV_VAL;
				default: next_rdata = `PMCS_RD_NONE;
			endcase
		end
	end

	// Handshake with the link domain
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			req_s        <= 2'h0;
			req_seen     <= 1'h0;
			xfer.ack_tog <= 1'h0;
			xfer.rdata   <= `PMCS_RD_NONE;
		end else begin
			req_s <= {req_s[0], xfer.req_tog};
			if (take) begin
				req_seen <= req_s[1];
			end
			if (take && xfer.kind == KIND_LOOK) begin
				xfer.rdata   <= next_rdata;
				xfer.ack_tog <= ~xfer.ack_tog;
			end
		end
	end

	// Settings store
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			for (int i = 0; i < NREG; i++) begin
				param[i] <= default_of(i[3:0]);
			end
		end else if (apply_write) begin
			param[wr_ix] <= wval;
		end else if (st == ST_LOAD) begin
			param[step] <= fl_holds ? fl_rdata : default_of(step);
		end
	end

	// Save and restore sequencer
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st   <= ST_IDLE;
			step <= 4'h0;
		end else begin
			case (st)
				ST_IDLE: begin
					step <= 4'h0;
					if (save_go) begin
						st <= ST_SAVE;
					end else if (load_go) begin
						st <= ST_LOAD;
					end
				end
				ST_SAVE, ST_LOAD: begin
					if (step == 4'(NREG - 1)) begin
						st   <= ST_IDLE;
						step <= 4'h0;
					end else begin
						step <= step + 4'h1;
					end
				end
				default: begin
					st   <= ST_IDLE;
					step <= 4'h0;
				end
			endcase
		end
	end

	// Flash unlock, consumed by a save
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			unlocked <= 1'h0;
		end else if (key_go) begin
			unlocked <= 1'h1;
		end else if (save_go) begin
			unlocked <= 1'h0;
		end
	end

	// Faults and alert line, a new event wins over a clear
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_faults   <= '0;
			o_alert_oe <= 1'h0;
			o_alert_n  <= 1'h0;
		end else begin
			o_faults   <= (clear_go ? '0 : o_faults) | i_fault_evt;
			o_alert_oe <= |o_faults;
			o_alert_n  <= 1'h0;
		end
	end

	// On/off pin filter and output enable
	assign pin_on = param[`PMCS_IX_ONOFF][`PMCS_ONOFF_POL] ? pin_q : !pin_q;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pin_p       <= 3'h0;
			pin_q       <= 1'h0;
			o_output_on <= 1'h0;
		end else begin
			pin_p <= {pin_p[1:0], i_on_off_pin};
			if (pin_p[1] == pin_p[2]) begin
				pin_q <= pin_p[2];
			end
			o_output_on <= !param[`PMCS_IX_ONOFF][`PMCS_ONOFF_PU] ||
				((!param[`PMCS_IX_ONOFF][`PMCS_ONOFF_CMD] || param[`PMCS_IX_OP][`PMCS_OP_ON]) &&
				(!param[`PMCS_IX_ONOFF][`PMCS_ONOFF_CPR] || pin_on));
		end
	end

	assign o_vout_setpoint  = param[`PMCS_IX_VSET];
	assign o_ov_fault_limit = param[`PMCS_IX_OVF];
	assign o_ov_warn_limit  = param[`PMCS_IX_OVW];
	assign o_oc_fault_limit = param[`PMCS_IX_OCF];
	assign o_oc_warn_limit  = param[`PMCS_IX_OCW];
	assign o_overtemperature_fault_limit = param[`PMCS_IX_OTF];

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	sequence s_save_cmd;
		save_go;
	endsequence

	sequence s_save_run;
		(st == ST_SAVE && fl_we) [*8];
	endsequence

	op_reset_a: assert property ($fell(i_rst) |-> param[`PMCS_IX_OP] == `PMCS_OP_RST)
		else $error("operation byte not at reset value");
	guard_reset_a: assert property ($fell(i_rst) |-> param[`PMCS_IX_WP] == `PMCS_WP_RST)
		else $error("write guard not at reset value");
	save_walk_a: assert property (s_save_cmd |=> s_save_run ##1 st == ST_SAVE ##1 st == ST_IDLE)
		else $error("save did not walk all settings");
	save_lock_a: assert property (commit && xfer.cmd == `PMCS_CMD_SAVE && !unlocked |=> st == ST_IDLE)
		else $error("save ran without unlock");
	load_running_a: assert property (commit && xfer.cmd == `PMCS_CMD_LOAD && o_output_on |=> st == ST_IDLE)
		else $error("restore ran while output on");
	vset_read_a: assert property (take && xfer.kind == KIND_LOOK && xfer.cmd == `PMCS_CMD_VSET
		|=> xfer.rdata == `PMCS_VSET_RST && $changed(xfer.ack_tog))
		else $error("setpoint read wrong");
	freq_read_a: assert property (take && xfer.kind == KIND_LOOK && xfer.cmd == `PMCS_CMD_FREQ
		|=> xfer.rdata == {`PMCS_FREQ_EXP, $past(i_freq_khz[11:1])})
		else $error("frequency read wrong");
	ovf_range_a: assert property (in_win(param[`PMCS_IX_OVF], `PMCS_OVF_MIN, `PMCS_OVF_MAX))
		else $error("overvoltage fault limit out of range");
	ovw_range_a: assert property (in_win(param[`PMCS_IX_OVW], `PMCS_OVW_MIN, `PMCS_OVW_MAX))
		else $error("overvoltage warning limit out of range");
	ocf_range_a: assert property (in_win(param[`PMCS_IX_OCF], `PMCS_OCF_MIN, `PMCS_OCF_MAX))
		else $error("overcurrent fault limit out of range");
	oc_order_a: assert property (param[`PMCS_IX_OCW] < param[`PMCS_IX_OCF])
		else $error("overcurrent warning not below fault");
	otf_range_a: assert property (in_win(param[`PMCS_IX_OTF], `PMCS_OTF_MIN, `PMCS_OTF_MAX))
		else $error("overtemperature fault limit out of range");
	rev_read_a: assert property (take && xfer.kind == KIND_LOOK && xfer.cmd == `PMCS_CMD_REV
		|=> xfer.rdata == `PMCS_REV_VAL)
		else $error("revision read wrong");
	mode_read_a: assert property (take && xfer.kind == KIND_LOOK && xfer.cmd == `PMCS_CMD_MODE
		|=> xfer.rdata == `PMCS_MODE_VAL)
		else $error("format byte read wrong");
	clear_alert_a: assert property (clear_go && i_fault_evt == '0 |=> o_faults == '0 ##1 !o_alert_oe)
		else $error("fault clear did not release alert");
	ro_write_a: assert property (commit && xfer.cmd == `PMCS_CMD_VSET |=> $stable(param[`PMCS_IX_VSET]))
		else $error("read-only setpoint changed");
	guard_block_a: assert property (commit && param[`PMCS_IX_WP][7:0] == `PMCS_WP_ALL &&
		xfer.cmd != `PMCS_CMD_WP |=> $stable(param[`PMCS_IX_OP]) && $stable(param[`PMCS_IX_OVF]))
		else $error("write passed the guard");
endmodule

// [dv/pmcs_host.sv]
// Bus host model for the command set handler
`timescale 1ns/1ps
module pmcs_host #(
	parameter logic [6:0] ADDR = 7'h60
) (
	input  wire logic i_clock,
	input  wire logic i_dev_oe,
	output logic      o_scl,
	output logic      o_sda
);
	logic       oe = 1'b0;
	logic [7:0] rb;
	// Wired-AND data line with pull-up
	assign o_sda = !(oe | i_dev_oe);
	initial o_scl = 1'b1;
	task automatic hp();
		repeat (8) @(negedge i_clock);
	endtask
	task automatic bitx(input logic b, output logic r);
		@(negedge i_clock);
		oe = !b;
		hp();
		o_scl = 1'b1;
		hp();
		r = o_sda;
		o_scl = 1'b0;
	endtask
	task automatic start();
		@(negedge i_clock);
		oe = 1'b0;
		hp();
		o_scl = 1'b1;
		hp();
		oe = 1'b1;
		hp();
		o_scl = 1'b0;
	endtask
	task automatic stop();
		@(negedge i_clock);
		oe = 1'b1;
		hp();
		o_scl = 1'b1;
		hp();
		oe = 1'b0;
		repeat (3) hp();
	endtask
	task automatic bx(input logic [7:0] d, input logic nak);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], rb[i]);
		end
		bitx(nak, a);
	endtask
	task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
		start();
		bx({ADDR, 1'b0}, 1'b1);
		bx(c, 1'b1);
		if (n > 0) bx(d[7:0], 1'b1);
		if (n > 1) bx(d[15:8], 1'b1);
		stop();
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		start();
		bx({ADDR, 1'b0}, 1'b1);
		bx(c, 1'b1);
		start();
		bx({ADDR, 1'b1}, 1'b1);
		bx(8'hff, 1'b0);
		d[7:0] = rb;
		bx(8'hff, 1'b1);
		d[15:8] = rb;
		stop();
	endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench of the command set handler
`timescale 1ns/1ps
module testbench;
	logic        i_clock;
	logic        i_rst = 1'b1;
	logic        lclk;
	logic        pin = 1'b0;
	logic [7:0]  evt = 8'h00;
	logic [11:0] khz = 12'h1f4;
	logic        scl, sda, dev_oe, on, al_oe, sda_o, al_n;
	logic [7:0]  flt;
	logic [15:0] vs, ovf, ovw, ocf, ocw, otf, r;
	int          mismatches = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	pmcs_handler uut (.i_clock(i_clock), .i_rst(i_rst), .i_link_clock(lclk), .i_link_rst(i_rst), .i_scl(scl),
		.i_sda(sda), .o_sda(sda_o), .o_sda_oe(dev_oe), .i_on_off_pin(pin), .i_fault_evt(evt), .i_freq_khz(khz),
		.o_output_on(on), .o_alert_n(al_n), .o_alert_oe(al_oe), .o_faults(flt), .o_vout_setpoint(vs),
		.o_ov_fault_limit(ovf), .o_ov_warn_limit(ovw), .o_oc_fault_limit(ocf), .o_oc_warn_limit(ocw),
		.o_overtemperature_fault_limit(otf));
	pmcs_host host (.i_clock(i_clock), .i_dev_oe(dev_oe), .o_scl(scl), .o_sda(sda));
	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	initial begin
		lclk = 1'b0;
		#3.7;
		forever #6 lclk = ~lclk;
	end
	task automatic ck(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic t_defaults();
		ck(ocf, 16'heb50);
		ck(otf, 16'hf208);
		host.rd(8'h21, r);
		ck(r, 16'hc333);
		host.rd(8'h01, r);
		ck({8'h00, r[7:0]}, 16'h0080);
		host.rd(8'h10, r);
		ck({8'h00, r[7:0]}, 16'h0080);
		host.rd(8'h95, r);
		ck(r, 16'h08fa);
		host.rd(8'h40, r);
		ck(r, 16'hd800);
		host.rd(8'h20, r);
		ck({8'h00, r[7:0]}, 16'h0014);
		host.rd(8'h98, r);
		ck({8'h00, r[7:0]}, 16'h0022);
		host.rd(8'h02, r);
		ck({8'h00, r[7:0]}, 16'h001d);
	endtask
	task automatic t_guard();
		host.wr(8'h40, 2, 16'he000);
		ck(ovf, 16'hd800);
		host.wr(8'h10, 1, 16'h0000);
		host.wr(8'h40, 2, 16'he000);
		ck(ovf, 16'he000);
		host.wr(8'h40, 2, 16'he001);
		ck(ovf, 16'he000);
		host.wr(8'h4a, 2, 16'heb21);
		ck(ocw, 16'heb20);
		host.wr(8'h46, 2, 16'heb30);
		ck(ocf, 16'heb30);
		host.wr(8'h46, 2, 16'heb00);
		ck(ocf, 16'heb30);
		host.wr(8'h4f, 2, 16'hf21c);
		ck(otf, 16'hf21c);
		host.wr(8'h21, 2, 16'hc000);
		ck(vs, 16'hc333);
	endtask
	task automatic t_output();
		ck({15'h0, on}, 16'h0001);
		host.wr(8'h01, 1, 16'h0000);
		ck({15'h0, on}, 16'h0000);
	endtask
	task automatic t_clear();
		evt = 8'h04;
		@(negedge i_clock);
		evt = 8'h00;
		repeat (2) @(negedge i_clock);
		ck({8'h00, flt}, 16'h0004);
		host.wr(8'h03, 0, 16'h0000);
		ck({8'h00, flt}, 16'h0000);
		ck({15'h0, al_oe}, 16'h0000);
		ck({14'h0, al_n, sda_o}, 16'h0000);
	endtask
	task automatic t_flash();
		host.wr(8'h42, 2, 16'hc000);
		ck(ovw, 16'hc000);
		host.wr(8'h11, 0, 16'h0000);
		host.wr(8'h12, 0, 16'h0000);
		ck(ovf, 16'hd800);
		host.wr(8'h10, 1, 16'h0000);
		host.wr(8'h01, 1, 16'h0000);
		host.wr(8'h42, 2, 16'hc000);
		host.wr(8'hec, 2, 16'h157e);
		host.wr(8'h11, 0, 16'h0000);
		host.wr(8'h42, 2, 16'hd000);
		host.wr(8'h12, 0, 16'h0000);
		ck(ovw, 16'hc000);
		ck({15'h0, on}, 16'h0000);
	endtask
	initial begin
		repeat (5) @(negedge i_clock);
		i_rst = 1'b0;
		repeat (10) @(negedge i_clock);
		t_defaults();
		t_guard();
		t_output();
		t_clear();
		t_flash();
		close_out();
	end
endmodule
